//--- acsl_top.sv
/*
  acsl_top: control, status and result registers of a 10-bit converter
  with sixteen inputs in four groups of four, apb slave for software.
  assumes: the conversion core runs on pclk, takes a one-cycle request
  and answers with a one-cycle done pulse carrying the result.
*/
// Design decision made here: register access over APB.
// Functional notes
// - single mode sets end flag when the chosen channel finishes.
// - scan mode sets end flag only after every chosen channel finishes.
// - end flag clears on a 0 write only after it was read as 1.
// - a transfer controller read of a result register clears end flag while ie is set.
// - software may only write 0 to end flag; writing 1 does nothing.
// - results split: bits 9..2 high byte, bits 1..0 at low bits 7..6.
// - control/status holds flag, ie, start, scan, cks, three channel bits.
// - second control holds trigger bits 7..6, cks high bit 3, channel bit 2.
// - group bit picks inputs 0-3 or 4-7 (8-11 or 12-15 with extra set); scan runs first..indexed input.
`timescale 1ns/1ps
module acsl_top
  import acsl_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // access made by the transfer controller
  input  wire logic              xfer_access,
  // conversion core
  output acsl_conv_req_t         conv_req,
  input  wire acsl_conv_rsp_t    conv_rsp,
  // triggers and power state
  input  wire logic              timer_trigger,
  input  wire logic              ext_trigger,
  input  wire logic              standby,
  // interrupt request
  output logic                   conversion_end_interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [15:0] acsl_word(input logic [ADDR_W-1:0] a);
    acsl_word = 16'(a[ADDR_W-1:2]);
  endfunction

  function automatic logic acsl_is_result(input logic [15:0] w);
    acsl_is_result = (w >= ACSL_IDX_RES_A_HIGH) && (w <= ACSL_IDX_RES_D_LOW);
  endfunction

  function automatic logic acsl_is_mapped(input logic [15:0] w);
    acsl_is_mapped = acsl_is_result(w) || (w == ACSL_IDX_CTRL_STAT) ||
                     (w == ACSL_IDX_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // external trigger pin

  logic ext_level;
  logic ext_level_q;
  logic ext_rise;

  acsl_sync3 u_ext_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .din    (ext_trigger),
    .stable (ext_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_level_q <= 1'b0;
    end else begin
      ext_level_q <= ext_level;
    end
  end

  assign ext_rise = ext_level & ~ext_level_q;

  ////////////////////////////////////////////////////////////////////////
  // state

  acsl_regs_t r;
  acsl_regs_t next_r;

  logic [15:0] word;
  logic        setup;
  logic        access;
  logic        wr_ok;
  logic        rd_ok;
  logic [7:0]  csr_byte;
  logic [7:0]  cr_byte;
  logic [7:0]  rd_byte;
  logic        hw_trigger;
  logic        set_flag;
  logic        clr_flag;
  logic [2:0]  rel;

  assign word   = acsl_word(paddr);
  assign setup  = psel & ~penable;
  assign access = psel & penable & r.pready;
  assign wr_ok  = access & pwrite & pstrb[0] & acsl_is_mapped(word);
  assign rd_ok  = access & ~pwrite & acsl_is_mapped(word);

  // flag, ie, start, scan, cks, channel
  assign csr_byte = {r.csr.end_flag, r.csr.end_ie, r.csr.start, r.csr.scan,
                     r.csr.cks_lo, r.csr.group, r.csr.index};
  // trigger, cks high, extra bit; unused read 0
  assign cr_byte  = {r.cr.trig, 2'h0, r.cr.cks_hi, r.cr.extra, 2'h0};

  assign hw_trigger = ((r.cr.trig == ACSL_TRG_TIMER) & timer_trigger) |
                      ((r.cr.trig == ACSL_TRG_EXT_PIN) & ext_rise);

  assign rel = 3'(word - ACSL_IDX_RES_A_HIGH);

  ////////////////////////////////////////////////////////////////////////
  // read data mux

  always_comb begin
    rd_byte = 8'h00;
    if (acsl_is_result(word)) begin
      if (!rel[0]) begin
        rd_byte = r.result[rel[2:1]][9:2];
      end else begin
        rd_byte = {r.result[rel[2:1]][1:0], 6'h00};
      end
    end else if (word == ACSL_IDX_CTRL_STAT) begin
      rd_byte = csr_byte;
    end else if (word == ACSL_IDX_CTRL) begin
      rd_byte = cr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    set_flag = 1'b0;
    clr_flag = 1'b0;

    // zero wait: ready rises in the access phase
    next_r.pready  = setup;
    next_r.pslverr = setup & ~acsl_is_mapped(word);
    next_r.prdata  = 32'h0000_0000;
    if (setup & ~pwrite) begin
      next_r.prdata = {24'h00_0000, rd_byte};
    end

    next_r.conv.req = 1'b0;

    // register writes
    if (wr_ok && word == ACSL_IDX_CTRL_STAT) begin
      next_r.csr.end_ie = pwdata[ACSL_CSR_IE_BIT];
      next_r.csr.start  = pwdata[ACSL_CSR_START_BIT];
      next_r.csr.scan   = pwdata[ACSL_CSR_SCAN_BIT];
      next_r.csr.cks_lo = pwdata[ACSL_CSR_CKS_BIT];
      next_r.csr.group  = pwdata[ACSL_CSR_GROUP_BIT];
      next_r.csr.index  = {pwdata[ACSL_CSR_IDX_HI_BIT], pwdata[ACSL_CSR_IDX_LO_BIT]};
      // clear only after read as 1
      if (!pwdata[ACSL_CSR_FLAG_BIT] && r.armed) begin
        clr_flag = 1'b1;
      end
      next_r.armed = 1'b0;
    end
    if (wr_ok && word == ACSL_IDX_CTRL) begin
      next_r.cr.trig   = {pwdata[ACSL_CR_TRG_HI_BIT], pwdata[ACSL_CR_TRG_LO_BIT]};
      next_r.cr.cks_hi = pwdata[ACSL_CR_CKS_HI_BIT];
      next_r.cr.extra  = pwdata[ACSL_CR_EXTRA_BIT];
    end

    // arm on reading the flag set
    if (rd_ok && word == ACSL_IDX_CTRL_STAT && r.csr.end_flag) begin
      next_r.armed = 1'b1;
    end

    if (rd_ok && xfer_access && acsl_is_result(word) && r.irq) begin
      clr_flag = 1'b1;
    end

    if (hw_trigger) begin
      next_r.csr.start = 1'b1;
    end

    // conversion sequencing
    case (r.state)
      ACSL_IDLE: begin
        if (next_r.csr.start && !standby) begin
          // scan begins at group's first input
          next_r.cur          = next_r.csr.scan ? 2'h0 : next_r.csr.index;
          next_r.conv.req     = 1'b1;
          next_r.conv.channel = {next_r.cr.extra, next_r.csr.group, next_r.cur};
          next_r.conv.clk_sel = {next_r.cr.cks_hi, next_r.csr.cks_lo};
          next_r.state        = ACSL_WAIT;
        end
      end
      ACSL_WAIT: begin
        if (conv_rsp.done) begin
          next_r.result[r.cur] = conv_rsp.data;
          next_r.state         = ACSL_IDLE;
          if (!r.csr.scan) begin
            if (r.csr.start) begin
              set_flag = 1'b1;
            end
            next_r.csr.start = 1'b0;
          end else begin
            // scan up to the indexed input
            if (r.cur == r.csr.index) begin
              set_flag   = 1'b1;
              next_r.cur = 2'h0;
            end else begin
              next_r.cur = 2'(r.cur + 2'h1);
            end
            if (next_r.csr.start && !standby) begin
              next_r.conv.req     = 1'b1;
              next_r.conv.channel = {next_r.cr.extra, next_r.csr.group, next_r.cur};
              next_r.conv.clk_sel = {next_r.cr.cks_hi, next_r.csr.cks_lo};
              next_r.state        = ACSL_WAIT;
            end
          end
        end
      end
      default: begin
        next_r.state = ACSL_IDLE;
      end
    endcase

    if (standby) begin
      next_r.csr.start = 1'b0;
      next_r.state     = ACSL_IDLE;
      next_r.conv.req  = 1'b0;
    end

    // set wins over clear
    if (set_flag) begin
      next_r.csr.end_flag = 1'b1;
    end else if (clr_flag) begin
      next_r.csr.end_flag = 1'b0;
    end
    if (!next_r.csr.end_flag) begin
      next_r.armed = 1'b0;
    end

    next_r.irq = next_r.csr.end_flag & next_r.csr.end_ie;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state   <= ACSL_IDLE;
      r.csr     <= ACSL_CSR_RESET;
      r.cr      <= acsl_cr_t'({ACSL_CR_RESET[7:6], ACSL_CR_RESET[3:2]});
      r.result  <= '0;
      r.cur     <= 2'h0;
      r.armed   <= 1'b0;
      r.pready  <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata  <= 32'h0000_0000;
      r.conv    <= '0;
      r.irq     <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops

  assign pready                   = r.pready;
  assign prdata                   = r.prdata;
  assign pslverr                  = r.pslverr;
  assign conv_req                 = r.conv;
  assign conversion_end_interrupt = r.irq;

endmodule

//--- acsl_pkg.sv
/*
  acsl_pkg: shared constants, state types and carrier structs of the
  converter control/status block.
  assumes: one clock domain, registers reached as 32-bit apb words.
*/
package acsl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [15:0] ACSL_IDX_RES_A_HIGH = 16'hff90;
  localparam logic [15:0] ACSL_IDX_RES_A_LOW  = 16'hff91;
  localparam logic [15:0] ACSL_IDX_RES_B_HIGH = 16'hff92;
  localparam logic [15:0] ACSL_IDX_RES_B_LOW  = 16'hff93;
  localparam logic [15:0] ACSL_IDX_RES_C_HIGH = 16'hff94;
  localparam logic [15:0] ACSL_IDX_RES_C_LOW  = 16'hff95;
  localparam logic [15:0] ACSL_IDX_RES_D_HIGH = 16'hff96;
  localparam logic [15:0] ACSL_IDX_RES_D_LOW  = 16'hff97;
  localparam logic [15:0] ACSL_IDX_CTRL_STAT  = 16'hff98;
  localparam logic [15:0] ACSL_IDX_CTRL       = 16'hff99;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ACSL_CSR_FLAG_BIT   = 7;
  localparam int ACSL_CSR_IE_BIT     = 6;
  localparam int ACSL_CSR_START_BIT  = 5;
  localparam int ACSL_CSR_SCAN_BIT   = 4;
  localparam int ACSL_CSR_CKS_BIT    = 3;
  localparam int ACSL_CSR_GROUP_BIT  = 2;
  localparam int ACSL_CSR_IDX_HI_BIT = 1;
  localparam int ACSL_CSR_IDX_LO_BIT = 0;
  localparam int ACSL_CR_TRG_HI_BIT  = 7;
  localparam int ACSL_CR_TRG_LO_BIT  = 6;
  localparam int ACSL_CR_CKS_HI_BIT  = 3;
  localparam int ACSL_CR_EXTRA_BIT   = 2;

  ////////////////////////////////////////////////////////////////////////
  // reset values and trigger source codes
  localparam logic [7:0] ACSL_CSR_RESET   = 8'h00;
  localparam logic [7:0] ACSL_CR_RESET    = 8'h00;
  localparam logic [1:0] ACSL_TRG_TIMER   = 2'h1;
  localparam logic [1:0] ACSL_TRG_EXT_PIN = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ACSL_IDLE = 2'b01,
    ACSL_WAIT = 2'b10
  } acsl_state_t;

  typedef struct packed {
    logic       end_flag;
    logic       end_ie;
    logic       start;
    logic       scan;
    logic       cks_lo;
    logic       group;
    logic [1:0] index;
  } acsl_csr_t;

  typedef struct packed {
    logic [1:0] trig;
    logic       cks_hi;
    logic       extra;
  } acsl_cr_t;

  // request towards the conversion core
  typedef struct packed {
    logic       req;
    logic [3:0] channel;
    logic [1:0] clk_sel;
  } acsl_conv_req_t;

  // answer from the conversion core
  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } acsl_conv_rsp_t;

  typedef struct packed {
    acsl_state_t     state;
    acsl_csr_t       csr;
    acsl_cr_t        cr;
    logic [3:0][9:0] result;
    logic [1:0]      cur;
    logic            armed;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    acsl_conv_req_t  conv;
    logic            irq;
  } acsl_regs_t;

endpackage

//--- acsl_sync3.sv
/*
  acsl_sync3: three-stage synchroniser for a pin input.
  assumes: din is asynchronous to clk; the stable output only moves
  once the second and third stages agree.
*/
`timescale 1ns/1ps
module acsl_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic din,
  // clock side
  output logic      stable
);

  logic [2:0] stage;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage  <= 3'h0;
      stable <= 1'b0;
    end else begin
      stage <= {stage[1:0], din};
      // first stage feeds only the second
      if (stage[1] == stage[2]) begin
        stable <= stage[2];
      end
    end
  end

endmodule

//--- acsl_checker.sv
/*
  acsl_checker: port-level assertions for acsl_top.
  assumes: bound into acsl_top, single pclk domain.
*/
`timescale 1ns/1ps
module acsl_checker
  import acsl_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              xfer_access,
  // core and interrupt
  input wire acsl_conv_req_t    conv_req,
  input wire acsl_conv_rsp_t    conv_rsp,
  input wire logic              conversion_end_interrupt
);
  //////////////////////////////////////////////////////////////////////////
  // shadow of written control bits; the flag itself is not visible here
  logic [7:0] csr_sh;
  logic       extra_sh;
  logic       cks_hi_sh;
  wire [15:0] idx = paddr[ADDR_W-1:2];
  wire        wr_ok = psel && penable && pready && pwrite && pstrb[0];
  wire        res_idx = idx[15:3] == 13'h1ff2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_sh <= 8'h00;
      extra_sh <= 1'b0;
      cks_hi_sh <= 1'b0;
    end else if (wr_ok && idx == ACSL_IDX_CTRL_STAT) begin
      csr_sh <= pwdata[7:0];
    end else if (wr_ok && idx == ACSL_IDX_CTRL) begin
      extra_sh <= pwdata[2];
      cks_hi_sh <= pwdata[3];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  rdy_after_setup_a: assert property (
    psel && !penable |=> pready && penable) else $error("no ready after setup");
  hi_bits_zero_a: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  low_unused_a: assert property (
    pready && !pwrite && res_idx && idx[0] |-> prdata[5:0] == 6'h0)
    else $error("unused result bits set");
  start_req_a: assert property (
    wr_ok && idx == ACSL_IDX_CTRL_STAT && pwdata[5] |=> conv_req.req)
    else $error("start gave no request");
  req_pulse_a: assert property (
    conv_req.req |=> !conv_req.req) else $error("request longer than one cycle");
  single_chan_a: assert property (
    conv_req.req && !csr_sh[4] |-> conv_req.channel == {extra_sh, csr_sh[2:0]})
    else $error("wrong single channel");
  single_end_a: assert property (
    conv_rsp.done && !csr_sh[4] && csr_sh[6] |-> ##[1:2] conversion_end_interrupt)
    else $error("no end flag after single");
  clk_sel_a: assert property (
    conv_req.req |-> conv_req.clk_sel == {cks_hi_sh, csr_sh[3]})
    else $error("wrong clock select");
  ie_gate_a: assert property (
    $rose(conversion_end_interrupt) |-> csr_sh[6]) else $error("irq without enable");
  xfer_clear_a: assert property (
    psel && penable && pready && !pwrite && xfer_access && res_idx
      && conversion_end_interrupt |-> ##[1:2] !conversion_end_interrupt)
    else $error("transfer read kept flag");
endmodule

bind acsl_top acsl_checker #(.ADDR_W(ADDR_W)) acsl_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .xfer_access(xfer_access),
  .conv_req(conv_req), .conv_rsp(conv_rsp),
  .conversion_end_interrupt(conversion_end_interrupt)
);

//--- acsl_core_model.sv
/*
  acsl_core_model: behavioural conversion core.
  assumes: one-cycle request; done pulse dly+1 cycles later, dly >= 1.
*/
`timescale 1ns/1ps
module acsl_core_model
  import acsl_pkg::*;
(
  // clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // bench knobs
  input wire logic [3:0]     dly,
  input wire logic [9:0]     base,
  // block side
  input wire acsl_conv_req_t conv_req,
  output acsl_conv_rsp_t     conv_rsp
);
  logic [4:0] cnt;
  logic [3:0] ch;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 5'h0;
      ch <= 4'h0;
    end else if (conv_req.req) begin
      cnt <= {1'b0, dly} + 5'h1;
      ch <= conv_req.channel;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
    end
  end
  // data inverted outside done so a stale value never looks valid
  assign conv_rsp.done = cnt == 5'h1;
  assign conv_rsp.data = conv_rsp.done ? base ^ {6'h0, ch} : ~(base ^ {6'h0, ch});
endmodule

//--- adc_control_status_logic_tb_top.sv
/*
  adc_control_status_logic_tb_top: random self-checking bench.
  assumes: acsl_top with acsl_core_model as conversion core.
*/
`timescale 1ns/1ps
module adc_control_status_logic_tb_top;
  import acsl_pkg::*;
  logic            pclk = 0;
  logic            presetn = 0;
  logic            psel = 0;
  logic            penable = 0;
  logic            pwrite = 0;
  logic            xfer_access = 0;
  logic            timer_trigger = 0;
  logic            ext_trigger = 0;
  logic            standby = 0;
  logic [17:0]     paddr = 0;
  logic [31:0]     pwdata = 0;
  logic [3:0]      dly = 4'h1;
  logic [9:0]      base = 0;
  logic            pready, pslverr, irq;
  logic [31:0]     prdata;
  acsl_conv_req_t  conv_req;
  acsl_conv_rsp_t  conv_rsp;
  int              num_errors = 0;
  int              tests_run = 0;
  always #2 pclk = ~pclk;
  acsl_top acsl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .xfer_access(xfer_access), .conv_req(conv_req),
    .conv_rsp(conv_rsp), .timer_trigger(timer_trigger), .ext_trigger(ext_trigger),
    .standby(standby), .conversion_end_interrupt(irq));
  acsl_core_model acsl_core_model_i (.pclk(pclk), .presetn(presetn), .dly(dly),
    .base(base), .conv_req(conv_req), .conv_rsp(conv_rsp));
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] i, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int   n;
    logic rdy;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    // sample mid-cycle: the answer stands settled before the taking edge
    do begin
      @(negedge pclk);
      r = prdata;
      e = pslverr;
      rdy = pready;
      @(posedge pclk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, i, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [15:0] i, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(0, i, 8'h00, r, e);
    chk(nm, r, {24'h0, x});
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    @(negedge pclk);
    while (irq !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    chk("irq_set", irq, 1);
    @(posedge pclk);
  endtask
  task automatic chk_res(input int s, input int ch);
    logic [9:0] d;
    d = base ^ 10'(ch);
    rd("res_high", ACSL_IDX_RES_A_HIGH + 16'(2 * s), d[9:2]);
    rd("res_low", ACSL_IDX_RES_A_LOW + 16'(2 * s), {d[1:0], 6'h0});
  endtask
  task automatic irq_is(input logic x);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("irq", irq, x);
    @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    r = $urandom(74829);
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd("csr_reset", ACSL_IDX_CTRL_STAT, ACSL_CSR_RESET);
    rd("cr_reset", ACSL_IDX_CTRL, ACSL_CR_RESET);
    apb(0, 16'hff9a, 8'h00, r, e);
    chk("unmapped", e, 1);
    wr(ACSL_IDX_CTRL, 8'hff);
    rd("cr_bits", ACSL_IDX_CTRL, 8'hcc);
    for (int ch = 0; ch < 12; ch++) begin
      wr(ACSL_IDX_CTRL, ch < 8 ? 8'h00 : 8'h04);
      base <= 10'($urandom);
      dly <= 4'(1 + $urandom % 8);
      wr(ACSL_IDX_CTRL_STAT, 8'h60 | 8'(ch % 8));
      wait_irq();
      chk_res(ch % 4, ch);
      if (ch % 2 == 1) begin
        xfer_access <= 1;
        apb(0, ACSL_IDX_RES_A_HIGH, 8'h00, r, e);
        xfer_access <= 0;
      end else begin
        wr(ACSL_IDX_CTRL_STAT, 8'h40 | 8'(ch % 8));
        irq_is(1);
        rd("csr_done", ACSL_IDX_CTRL_STAT, 8'hc0 | 8'(ch % 8));
        wr(ACSL_IDX_CTRL_STAT, 8'h40 | 8'(ch % 8));
      end
      irq_is(0);
      wr(ACSL_IDX_CTRL_STAT, 8'hc0 | 8'(ch % 8));
      rd("flag_w1", ACSL_IDX_CTRL_STAT, 8'h40 | 8'(ch % 8));
    end
    wr(ACSL_IDX_CTRL, 8'h00);
    base <= 10'($urandom);
    dly <= 4'h3;
    wr(ACSL_IDX_CTRL_STAT, 8'h76);
    wait_irq();
    for (int s = 0; s < 3; s++) chk_res(s, s + 4);
    wr(ACSL_IDX_CTRL_STAT, 8'h56);
    repeat (20) @(posedge pclk);
    rd("scan_stop", ACSL_IDX_CTRL_STAT, 8'hd6);
    wr(ACSL_IDX_CTRL_STAT, 8'h16);
    irq_is(0);
    for (int t = 1; t < 3; t++) begin
      wr(ACSL_IDX_CTRL, 8'(t << 6));
      wr(ACSL_IDX_CTRL_STAT, 8'h41);
      base <= 10'($urandom);
      timer_trigger <= t == 1;
      ext_trigger <= t == 2;
      @(posedge pclk);
      timer_trigger <= 0;
      repeat (4) @(posedge pclk);
      ext_trigger <= 0;
      wait_irq();
      chk_res(1, 1);
      rd("trig_csr", ACSL_IDX_CTRL_STAT, 8'hc1);
      wr(ACSL_IDX_CTRL_STAT, 8'h01);
    end
    wr(ACSL_IDX_CTRL_STAT, 8'h70);
    standby <= 1;
    @(posedge pclk);
    standby <= 0;
    rd("standby", ACSL_IDX_CTRL_STAT, 8'h50);
    tally_and_finish();
  end
endmodule
